//--- rtl/acs_pkg.sv
// Purpose: constants, types and helpers of the conversion sequencer
// Assumes: 50 MHz REF_CLK; one instruction cycle is four oscillator periods
// Notes:   register map is a 32-bit AXI4-Lite word map, data in bits 7:0, port reads in bits 12:0
package acs_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ACS_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] ACS_PINCFG_ADDR = 8'h04;
  localparam logic [7:0] ACS_TIMING_ADDR = 8'h08;
  localparam logic [7:0] ACS_RESH_ADDR   = 8'h0C;
  localparam logic [7:0] ACS_RESL_ADDR   = 8'h10;
  localparam logic [7:0] ACS_STAT_ADDR   = 8'h14;
  localparam logic [7:0] ACS_PORT_ADDR   = 8'h18;

  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_GO_BIT   = 1;
  localparam int CTRL_CHAN_LSB = 2;
  localparam int PIN_PCFG_LSB  = 0;
  localparam int PIN_VCFG_LSB  = 4;
  localparam int TIM_CKS_LSB   = 0;
  localparam int TIM_ACQ_LSB   = 3;
  localparam int TIM_JUST_BIT  = 7;
  localparam int STAT_IRQ_BIT  = 0;

  localparam logic [3:0] PCFG_RST_ANALOG  = 4'h0;
  localparam logic [3:0] PCFG_RST_DIGITAL = 4'h7;
  localparam logic [2:0] ACQ_RST          = 3'h0;
  localparam logic [2:0] CKS_RST          = 3'h0;
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_SLVERR      = 2'h2;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ       = 50;
  localparam int TOSC_PER_TCY  = 4;
  localparam int POST_WAIT_TCY = 2;
  localparam int WAIT_CLKS     = POST_WAIT_TCY * TOSC_PER_TCY;
  localparam int CONV_BITS     = 13;
  localparam int STRAP_CLKS    = 3;
  localparam logic [3:0] WAIT_LAST  = 4'(WAIT_CLKS - 1);
  localparam logic [4:0] CONV_LAST  = 5'(CONV_BITS - 1);
  localparam logic [1:0] STRAP_LAST = 2'(STRAP_CLKS);

  typedef enum logic [2:0] {
    ST_SAMPLE = 3'h0,
    ST_DELAY  = 3'h1,
    ST_ACQ    = 3'h3,
    ST_CONV   = 3'h2,
    ST_WAIT   = 3'h6
  } acs_state_type;

  // acquisition length in bit periods
  function automatic logic [4:0] acs_acq_tad_f(input logic [2:0] s);
    case (s)
      3'h1:    return 5'h02;
      3'h2:    return 5'h04;
      3'h3:    return 5'h06;
      3'h4:    return 5'h08;
      3'h5:    return 5'h0C;
      3'h6:    return 5'h10;
      3'h7:    return 5'h14;
      default: return 5'h00;
    endcase
  endfunction : acs_acq_tad_f

  // oscillator periods per bit period: 000=2 100=4 001=8 101=16 010=32 110=64
  function automatic logic [6:0] acs_div_f(input logic [2:0] s);
    return 7'h01 << (3'({s[1:0], s[2]}) + 3'h1);
  endfunction : acs_div_f

  // analog pins are the low ones; high pins turn digital as the code rises
  function automatic logic [12:0] acs_analog_mask_f(input logic [3:0] p);
    return (p < 4'h3) ? 13'h1FFF : (13'h1FFF >> (p - 4'h2));
  endfunction : acs_analog_mask_f

endpackage : acs_pkg

//--- rtl/acs_sequencer.sv
// Purpose: acquisition and conversion sequencer of a 12-bit SAR converter
// Assumes: AXI4-Lite master, one write and one read outstanding at most
// Notes:   analog sample network and comparator sit outside this block
// Behaviour
// - nonzero acquisition select samples 2..20 bit periods, then converts itself
// - acquisition select 000: start stops sampling and converts, no interval
// - acquisition select resets to 000, manual mode
// - completion clears start, sets complete flag, resumes sampling
// - no status shows acquisition end or conversion begin; start stays set
// - a conversion lasts exactly 13 bit periods
// - clock select maps to 2,4,8,16,32,64 oscillator periods or rc clock
// - acquisition counts bit periods, so it scales with the clock select
// - manual start delays conversion by one instruction cycle
// - whatever level sits on the selected pin is converted
// - channel and direction bits never alter sequencing
// - port reads return zero on analog pins
// - a strap picks the reset value of the analog pin field
// - clearing start mid-conversion aborts and keeps the old result
// - after completion or abort wait 2 instruction cycles, then sample again
// - discharge before each sample (on enable, CAP_DISCHARGE rises in the same cycle as HOLD_CONNECT); disconnect the capacitor at conversion start
// - enable bit turns the block on; start only acts while enabled
// - result loads right justified when format is 1, left when 0
// - rc clock adds one instruction cycle before the clock runs
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module acs_sequencer
  import acs_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        RC_CLK_IN,
  input  wire logic        PORTB_ANALOG_RESET_CFG,
  input  wire logic [11:0] ADC_DATA_IN,
  input  wire logic [12:0] PIN_IN,
  output logic             HOLD_CONNECT,
  output logic             CAP_DISCHARGE,
  output logic             SAR_STEP,
  output logic [3:0]       CHANNEL_SEL,
  output logic [1:0]       VREF_CFG
);

  // ****************************************
  // synchronisers
  // ****************************************
  logic [2:0]  rc_s_q;
  logic [1:0]  strap_s_q;
  logic [11:0] adc_m_q;
  logic [11:0] adc_s_q;
  logic [12:0] pin_m_q;
  logic [12:0] pin_s_q;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rc_s_q    <= 3'h0;
      strap_s_q <= 2'h0;
      adc_m_q   <= 12'h000;
      adc_s_q   <= 12'h000;
      pin_m_q   <= 13'h0000;
      pin_s_q   <= 13'h0000;
    end else begin
      rc_s_q    <= {rc_s_q[1:0], RC_CLK_IN};
      strap_s_q <= {strap_s_q[0], PORTB_ANALOG_RESET_CFG};
      adc_m_q   <= ADC_DATA_IN;
      adc_s_q   <= adc_m_q;
      pin_m_q   <= PIN_IN;
      pin_s_q   <= pin_m_q;
    end
  end

  // ****************************************
  // bus slave handshake
  // ****************************************
  logic [7:0]  aw_addr_q;
  logic [7:0]  ar_addr_w;
  logic [7:0]  wdata_q;
  logic        wstrb0_q;
  logic        aw_full_q;
  logic        w_full_q;
  logic        wr_w;
  logic        wr_ok_w;
  logic        rd_ok_w;
  logic [31:0] rd_data_w;

  assign ar_addr_w = S_AXI_ARADDR;
  assign wr_w      = aw_full_q && w_full_q && !S_AXI_BVALID;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_addr_q     <= 8'h00;
      wdata_q       <= 8'h00;
      wstrb0_q      <= 1'b0;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_addr_q     <= S_AXI_AWADDR;
        aw_full_q     <= 1'b1;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        wdata_q      <= S_AXI_WDATA[7:0];
        wstrb0_q     <= S_AXI_WSTRB[0];
        w_full_q     <= 1'b1;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_w) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_ok_w ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd_data_w;
      S_AXI_RRESP   <= rd_ok_w ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  logic          en_q;
  logic          en_prev_q;
  logic          go_q;
  logic [2:0]    acq_q;
  logic [2:0]    cks_q;
  logic          just_q;
  logic [3:0]    pcfg_q;
  logic [1:0]    strap_cnt_q;
  logic          irq_q;
  logic [7:0]    res_hi_q;
  logic [7:0]    res_lo_q;
  logic          wr_ctrl_w;
  logic          done_w;
  logic [12:0]   analog_w;
  acs_state_type state_q;

  assign wr_ctrl_w = wr_w && wstrb0_q && (aw_addr_q == ACS_CTRL_ADDR);
  assign analog_w  = acs_analog_mask_f(pcfg_q);
  assign wr_ok_w   = (aw_addr_q <= ACS_STAT_ADDR) && (aw_addr_q[1:0] == 2'h0);
  assign rd_ok_w   = (ar_addr_w <= ACS_PORT_ADDR) && (ar_addr_w[1:0] == 2'h0);

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      en_q        <= 1'b0;
      en_prev_q   <= 1'b0;
      CHANNEL_SEL <= 4'h0;
      acq_q       <= ACQ_RST;
      cks_q       <= CKS_RST;
      just_q      <= 1'b0;
      VREF_CFG    <= 2'h0;
      pcfg_q      <= PCFG_RST_ANALOG;
      strap_cnt_q <= 2'h0;
    end else begin
      en_prev_q <= en_q;
      if (strap_cnt_q != STRAP_LAST) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
        if (strap_cnt_q + 2'h1 == STRAP_LAST) begin
          pcfg_q <= strap_s_q[1] ? PCFG_RST_ANALOG : PCFG_RST_DIGITAL;
        end
      end
      if (wr_w && wstrb0_q) begin
        case (aw_addr_q)
          ACS_CTRL_ADDR: begin
            en_q        <= wdata_q[CTRL_EN_BIT];
            CHANNEL_SEL <= wdata_q[CTRL_CHAN_LSB +: 4];
          end
          ACS_PINCFG_ADDR: begin
            pcfg_q   <= wdata_q[PIN_PCFG_LSB +: 4];
            VREF_CFG <= wdata_q[PIN_VCFG_LSB +: 2];
          end
          ACS_TIMING_ADDR: begin
            cks_q  <= wdata_q[TIM_CKS_LSB +: 3];
            acq_q  <= wdata_q[TIM_ACQ_LSB +: 3];
            just_q <= wdata_q[TIM_JUST_BIT];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // start flag: set by a write while enabled, cleared on completion
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      go_q <= 1'b0;
    end else if (!en_q) begin
      go_q <= 1'b0;
    end else if (wr_ctrl_w) begin
      go_q <= wdata_q[CTRL_GO_BIT];
    end else if (done_w) begin
      go_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_q <= 1'b0;
    end else if (done_w) begin
      irq_q <= 1'b1;
    end else if (wr_w && wstrb0_q && aw_addr_q == ACS_STAT_ADDR && wdata_q[STAT_IRQ_BIT]) begin
      irq_q <= 1'b0;
    end
  end

  // result pair holds its value on abort; only completion or a write changes it
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      res_hi_q <= 8'h00;
      res_lo_q <= 8'h00;
    end else if (done_w) begin
      if (just_q) begin
        res_hi_q <= {4'h0, adc_s_q[11:8]};
        res_lo_q <= adc_s_q[7:0];
      end else begin
        res_hi_q <= adc_s_q[11:4];
        res_lo_q <= {adc_s_q[3:0], 4'h0};
      end
    end else if (wr_w && wstrb0_q) begin
      if (aw_addr_q == ACS_RESH_ADDR) res_hi_q <= wdata_q;
      if (aw_addr_q == ACS_RESL_ADDR) res_lo_q <= wdata_q;
    end
  end

  // no read shows the sequencer phase, only the start flag
  always_comb begin
    rd_data_w = 32'h0000_0000;
    case (ar_addr_w)
      ACS_CTRL_ADDR:   rd_data_w[5:0]  = {CHANNEL_SEL, go_q, en_q};
      ACS_PINCFG_ADDR: rd_data_w[5:0]  = {VREF_CFG, pcfg_q};
      ACS_TIMING_ADDR: rd_data_w[7:0]  = {just_q, 1'b0, acq_q, cks_q};
      ACS_RESH_ADDR:   rd_data_w[7:0]  = res_hi_q;
      ACS_RESL_ADDR:   rd_data_w[7:0]  = res_lo_q;
      ACS_STAT_ADDR:   rd_data_w[0]    = irq_q;
      ACS_PORT_ADDR:   rd_data_w[12:0] = pin_s_q & ~analog_w;
      default:         rd_data_w       = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // sequencer
  // ****************************************
  acs_tick_if tk ();
  logic [4:0] cnt_q;
  logic [3:0] cyc_q;
  logic [4:0] acq_tad_w;
  logic       manual_w;
  logic       rc_w;
  logic [1:0] dly_tcy_w;
  logic [3:0] dly_last_w;
  logic       enter_conv_w;
  logic       leave_wait_w;

  assign tk.run     = (state_q == ST_ACQ) || (state_q == ST_CONV);
  assign tk.clk_sel = cks_q;
  assign tk.rc_edge = rc_s_q[1] && !rc_s_q[2];

  acs_tick_gen #(.CNT_W(7)) u_tick (
    .clk   (REF_CLK),
    .rst_n (RESET_N),
    .tk    (tk.gen)
  );

  assign acq_tad_w    = acs_acq_tad_f(acq_q);
  assign manual_w     = (acq_q == 3'h0);
  assign rc_w         = (cks_q[1:0] == 2'h3);
  assign dly_tcy_w    = {1'b0, manual_w} + {1'b0, rc_w};
  assign dly_last_w   = 4'(dly_tcy_w * TOSC_PER_TCY - 1);
  assign enter_conv_w = go_q && ((state_q == ST_DELAY && cyc_q == dly_last_w && manual_w)
                      || (state_q == ST_ACQ && tk.tick && cnt_q == acq_tad_w - 5'h01));
  assign done_w       = go_q && state_q == ST_CONV && tk.tick && cnt_q == CONV_LAST;
  assign leave_wait_w = en_q && state_q == ST_WAIT && cyc_q == WAIT_LAST;

  // channel and pin direction never enter this machine
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= ST_SAMPLE;
      cnt_q   <= 5'h00;
      cyc_q   <= 4'h0;
    end else if (!en_q) begin
      state_q <= ST_SAMPLE;
      cnt_q   <= 5'h00;
      cyc_q   <= 4'h0;
    end else begin
      case (state_q)
        ST_SAMPLE: begin
          cnt_q <= 5'h00;
          cyc_q <= 4'h0;
          if (go_q) begin
            state_q <= (dly_tcy_w != 2'h0) ? ST_DELAY : ST_ACQ;
          end
        end
        ST_DELAY: begin
          if (!go_q) begin
            state_q <= ST_WAIT;
            cyc_q   <= 4'h0;
          end else if (cyc_q == dly_last_w) begin
            cyc_q   <= 4'h0;
            state_q <= manual_w ? ST_CONV : ST_ACQ;
          end else begin
            cyc_q <= cyc_q + 4'h1;
          end
        end
        ST_ACQ: begin
          if (!go_q) begin
            state_q <= ST_WAIT;
            cyc_q   <= 4'h0;
          end else if (enter_conv_w) begin
            state_q <= ST_CONV;
            cnt_q   <= 5'h00;
          end else if (tk.tick) begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        ST_CONV: begin
          if (!go_q || done_w) begin
            state_q <= ST_WAIT;
            cyc_q   <= 4'h0;
          end else if (tk.tick) begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        ST_WAIT: begin
          if (leave_wait_w) begin
            state_q <= ST_SAMPLE;
          end
          cyc_q <= cyc_q + 4'h1;
        end
        default: state_q <= ST_SAMPLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      HOLD_CONNECT  <= 1'b0;
      CAP_DISCHARGE <= 1'b0;
      SAR_STEP      <= 1'b0;
    end else begin
      HOLD_CONNECT  <= en_q && !enter_conv_w && (state_q == ST_SAMPLE
                       || state_q == ST_DELAY || state_q == ST_ACQ);
      CAP_DISCHARGE <= leave_wait_w || (en_q && !en_prev_q);
      SAR_STEP      <= state_q == ST_CONV && go_q && tk.tick;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_delay_tcy;
    (state_q == ST_DELAY)[*4];
  endsequence
  sequence s_post_wait;
    (state_q == ST_WAIT)[*8];
  endsequence

  property p_acq_end;
    (state_q == ST_ACQ && go_q && tk.tick && cnt_q == acq_tad_w - 5'h01)
      |=> (state_q == ST_CONV && cnt_q == 5'h00);
  endproperty
  a_acq_end: assert property (p_acq_end) else $error("acquisition did not end");

  property p_manual;
    disable iff (!RESET_N || !go_q || !en_q)
    (state_q == ST_SAMPLE && go_q && manual_w && !rc_w) |=> s_delay_tcy ##1 (state_q == ST_CONV);
  endproperty
  a_manual: assert property (p_manual) else $error("manual start not one cycle late");

  property p_conv_done;
    done_w |=> (state_q == ST_WAIT && irq_q && !HOLD_CONNECT);
  endproperty
  a_conv_done: assert property (p_conv_done) else $error("completion not flagged");

  property p_conv_len;
    (state_q == ST_CONV && go_q && tk.tick && cnt_q < CONV_LAST) |=> (state_q == ST_CONV);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion ended early");

  property p_abort;
    (en_q && state_q == ST_CONV && !go_q) |=> (state_q == ST_WAIT && $stable(res_hi_q));
  endproperty
  a_abort: assert property (p_abort) else $error("abort altered result");

  property p_wait;
    disable iff (!RESET_N || !en_q)
    $rose(state_q == ST_WAIT) |-> s_post_wait ##1 (state_q == ST_SAMPLE && CAP_DISCHARGE);
  endproperty
  a_wait: assert property (p_wait) else $error("post wait length wrong");

  property p_hold;
    (state_q == ST_CONV) |-> !HOLD_CONNECT;
  endproperty
  a_hold: assert property (p_hold) else $error("capacitor connected in conversion");

  property p_disabled;
    !en_q |=> (state_q == ST_SAMPLE && !go_q);
  endproperty
  a_disabled: assert property (p_disabled) else $error("runs while disabled");

  property p_justify;
    (done_w && just_q) |=> (res_hi_q[7:4] == 4'h0 && res_lo_q == $past(adc_s_q[7:0]));
  endproperty
  a_justify: assert property (p_justify) else $error("right justify wrong");

endmodule : acs_sequencer

//--- rtl/acs_tick_gen.sv
// Purpose: conversion bit-period tick from the oscillator or the rc clock
// Assumes: rc_edge is already synchronised, one cycle per rc rising edge
// Notes:   tick is a one-cycle pulse, first one a full period after run rises, or at the next rc edge on the rc clock
`timescale 1ns/1ps
module acs_tick_gen
  import acs_pkg::*;
#(
  parameter int CNT_W = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  acs_tick_if.gen  tk
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] div_w;
  logic             tick_q;

  if (CNT_W < 7) begin : g_chk
    $error("acs_tick_gen: CNT_W below 7 cannot divide by 64");
  end

  assign div_w   = CNT_W'(acs_div_f(tk.clk_sel));
  assign tk.tick = tick_q;

  always_ff @(posedge clk or negedge rst_n) begin
    // idle count starts at one, so the registered tick lands a full period in
    if (!rst_n) begin
      cnt_q  <= CNT_W'(1);
      tick_q <= 1'b0;
    end else if (!tk.run) begin
      cnt_q  <= CNT_W'(1);
      tick_q <= 1'b0;
    end else if (tk.clk_sel[1:0] == 2'h3) begin
      tick_q <= tk.rc_edge;
    end else if (cnt_q == div_w - CNT_W'(1)) begin
      cnt_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + CNT_W'(1);
      tick_q <= 1'b0;
    end
  end

endmodule : acs_tick_gen

//--- rtl/acs_tick_if.sv
// Purpose: bit-period tick request and answer between sequencer and divider
// Assumes: single clock domain
// Notes:   run low holds the divider at its start
`timescale 1ns/1ps
interface acs_tick_if;
  logic       run;
  logic [2:0] clk_sel;
  logic       rc_edge;
  logic       tick;
  modport seq (output run, output clk_sel, output rc_edge, input tick);
  modport gen (input run, input clk_sel, input rc_edge, output tick);
endinterface : acs_tick_if

//--- verif/acs_sequencer_test.sv
// Purpose: self-checking bench of the conversion sequencer
// Assumes: AXI4-Lite master tasks, one 50 MHz clock, ready lines held high
// Notes:   the rc clock pin toggles freely at 10 MHz
`timescale 1ns/1ps
module acs_sequencer_test
  import acs_pkg::*;
;
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        strap   = 1'b1;
  logic        rc      = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic        wvalid  = 1'b0;
  logic [7:0]  araddr  = 8'h00;
  logic        arvalid = 1'b0;
  logic [11:0] din     = 12'h000;
  logic [12:0] pin     = 13'h0000;
  logic        awready, wready, bvalid, arready, rvalid, hold, step;
  logic [1:0]  bresp, rresp, wresp, r, vref;
  logic [31:0] rdata, v;
  logic [3:0]  chan;
  int          n_mismatch, checks_done, cyc, sar_n, gap_c, gap;
  int          hcs[7];
  logic [2:0]  codes[7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
  int          divs[7]  = '{2, 4, 8, 16, 32, 64, 0};

  always #10 clk = ~clk;
  // rc edges kept clear of the REF_CLK rising edges
  initial begin
    #5;
    forever #50 rc = ~rc;
  end

  acs_sequencer dut (
    .REF_CLK(clk), .RESET_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1),
    .RC_CLK_IN(rc), .PORTB_ANALOG_RESET_CFG(strap), .ADC_DATA_IN(din), .PIN_IN(pin),
    .HOLD_CONNECT(hold), .CAP_DISCHARGE(), .SAR_STEP(step), .CHANNEL_SEL(chan), .VREF_CFG(vref)
  );

  // ****************************************
  // step counting and timeout
  // ****************************************
  always @(posedge clk) begin
    gap_c <= step ? 1 : gap_c + 1;
    if (step) begin
      sar_n <= sar_n + 1;
      gap <= gap_c;
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awready === 1'b1 && !aw_ok) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !w_ok) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    wresp = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
  endtask : rd

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset(input logic s);
    strap <= s;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ACS_PINCFG_ADDR);
    chk(v, s ? 32'h0 : 32'h7);
    rd(ACS_TIMING_ADDR);
    chk(v, 32'h0);
  endtask : t_reset

  task automatic t_conv(input logic [7:0] tim, input logic [3:0] ch, input int div,
                        output int hc);
    int s;
    din <= {ch, tim};
    wr(ACS_TIMING_ADDR, tim);
    wr(ACS_CTRL_ADDR, {2'h0, ch, 2'h1});
    repeat (150) @(posedge clk);
    s = sar_n;
    wr(ACS_CTRL_ADDR, {2'h0, ch, 2'h3});
    hc = 0;
    while (hold === 1'b1 && hc < 5000) begin
      @(posedge clk);
      hc++;
    end
    v = 32'h0;
    for (int i = 0; i < 500 && v[0] !== 1'b1; i++) rd(ACS_STAT_ADDR);
    chk(v, 32'h1);
    chk(32'(sar_n - s), 32'd13);
    if (div != 0) chk(32'(gap), 32'(div));
    chk(32'(chan), 32'(ch));
    rd(ACS_CTRL_ADDR);
    chk(v, {26'h0, ch, 2'h1});
    rd(ACS_RESH_ADDR);
    chk(v, tim[7] ? {28'h0, ch} : {24'h0, ch, tim[7:4]});
    rd(ACS_RESL_ADDR);
    chk(v, tim[7] ? {24'h0, tim} : {24'h0, tim[3:0], 4'h0});
    wr(ACS_STAT_ADDR, 8'h01);
    rd(ACS_STAT_ADDR);
    chk(v, 32'h0);
  endtask : t_conv

  task automatic t_abort();
    wr(ACS_RESH_ADDR, 8'h55);
    wr(ACS_RESL_ADDR, 8'h66);
    wr(ACS_TIMING_ADDR, 8'h86);
    wr(ACS_CTRL_ADDR, 8'h03);
    repeat (200) @(posedge clk);
    wr(ACS_CTRL_ADDR, 8'h01);
    repeat (20) @(posedge clk);
    chk(32'(hold), 32'h1);
    rd(ACS_RESH_ADDR);
    chk(v, 32'h55);
    rd(ACS_RESL_ADDR);
    chk(v, 32'h66);
    rd(ACS_STAT_ADDR);
    chk(v, 32'h0);
  endtask : t_abort

  task automatic t_disabled();
    int s;
    wr(ACS_CTRL_ADDR, 8'h00);
    s = sar_n;
    wr(ACS_CTRL_ADDR, 8'h02);
    repeat (100) @(posedge clk);
    rd(ACS_CTRL_ADDR);
    chk(v, 32'h0);
    chk(32'(sar_n - s), 32'h0);
    chk(32'(hold), 32'h0);
  endtask : t_disabled

  task automatic t_port();
    pin <= 13'h1FFF;
    wr(ACS_PINCFG_ADDR, 8'h3B);
    chk(32'(vref), 32'h3);
    rd(ACS_PORT_ADDR);
    chk({24'h0, v[7:0]}, 32'hF0);
    wr(ACS_PINCFG_ADDR, 8'h0F);
    rd(ACS_PORT_ADDR);
    chk({24'h0, v[7:0]}, 32'hFF);
    wr(8'h1C, 8'hFF);
    chk(32'(wresp), 32'(RESP_SLVERR));
    rd(8'h1C);
    chk(32'(r), 32'(RESP_SLVERR));
  endtask : t_port

  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  initial begin
    int h;
    t_reset(1'b1);
    wr(ACS_CTRL_ADDR, 8'h01);
    repeat (100) @(posedge clk);
    for (int i = 0; i < 7; i++) t_conv({5'h10, codes[i]}, 4'(i * 2 + 3), divs[i], hcs[i]);
    t_conv(8'h14, 4'h1, 4, h);
    chk(32'(h - hcs[1]), 32'(16 - TOSC_PER_TCY));
    t_abort();
    t_disabled();
    t_port();
    t_reset(1'b0);
    finish_test();
  end
endmodule : acs_sequencer_test
